// file: inc/nubus_port_params.svh
// Constants for the single transfer bus port: timing, codes, encodings.
// Assumes a 200 MHz system clock sampling the 10 MHz bus clock pin.
// Operation
// - Drive bus outputs after bus clock rises, sample inputs on its falling edge.
// - Bus reset is asynchronous; one bus period asserted fully initialises the port.
// - Slot code comes from the four ID lines; all low is slot F.
// - Claim slot space: top digit F and address bits 27-24 equal slot.
// - Optionally claim super slot space: address bits 31-28 equal slot.
// - Power fail line is asynchronous warning; card may drive it for power control.
// - Slave-only card requests service with the non-master request line.
// - A released three-state line is undefined one cycle, unasserted the next.
// - Control, address/data and parity lines are three-state, released when not owner.
// - Master asserts start for exactly one bus period per transaction.
// - Addressed slave asserts acknowledge for exactly one bus period.
// - Mode lines carry operation at start and acknowledge type at acknowledge.
// - Address/data lines carry address first, data later.
// - No parity generated: never assert parity valid; ignore parity lines.
// - Bits 31-2 select the word; low bits with mode select the part.
// - Mode decode: TM1 low write; TM0 low bytes 3..0, high halfword/block/word.
// - Data unjustified: byte n of word travels on lanes 8n up to 8n+7.
// - Single transfer is one start cycle then one acknowledge cycle.
// - Master drives start with mode, low address bits and address.
// - Master writes data from second period until acknowledged.
// - Slave places read data in the acknowledge period.
// - Acknowledge status: LL complete, LH error, HL timeout, HH try again.
// - Slave recognises start only with start asserted and acknowledge not.
// - Master drives acknowledge unasserted during its start cycle.
`ifndef NUBUS_PORT_PARAMS_SVH
`define NUBUS_PORT_PARAMS_SVH

`define CLK_RATE_MHZ      200
`define BUS_TIMEOUT       256
`define RESET_HOLD_NS     100
`define RESET_HOLD_CYC    ((`RESET_HOLD_NS * `CLK_RATE_MHZ + 999) / 1000)
`define SLOT_SPACE_DIGIT  4'hf
`define ACK_COMPLETE      2'h0
`define ACK_ERROR         2'h1
`define ACK_TIMEOUT       2'h2
`define ACK_RETRY         2'h3
`define WRITE_LOW_WAIT    4'h0

`endif

// file: inc/nubus_port_pkg.sv
// Types for the single transfer bus port.
// Assumes the params header is included by users of these types.
package nubus_port_pkg;
    typedef enum logic [2:0] {
        IDLE   = 3'b000,
        MSTART = 3'b001,
        MWAIT  = 3'b010,
        MREL   = 3'b011,
        SWAIT  = 3'b100,
        SACK   = 3'b101,
        SREL   = 3'b110
    } state_t;
endpackage

// file: inc/bus_sample_if.sv
// Carries sampled, inverted bus inputs from the sampler to the port.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface bus_sample_if;
    logic        sample;
    logic        drive;
    logic        start;
    logic        ack;
    logic [1:0]  tm;
    logic [31:0] ad;
    logic [3:0]  slot;
    logic        busReset;
    logic        powerFail;
    modport src (output sample, drive, start, ack, tm, ad, slot, busReset, powerFail);
    modport dst (input sample, drive, start, ack, tm, ad, slot, busReset, powerFail);
endinterface

// file: hw/bus_sampler.sv
// Synchronises bus pins, finds bus clock edges, captures inputs on falling edge.
// Assumes raw active-low pins asynchronous to clk.
`timescale 1ns/100ps
`include "nubus_port_params.svh"
module bus_sampler (
    // System
    input  wire logic        clk,
    input  wire logic        rst,
    // Raw pins, active low
    input  wire logic        busClkPin,
    input  wire logic        resetPin_n,
    input  wire logic [3:0]  idPin_n,
    input  wire logic        pfwPin_n,
    input  wire logic        startPin_n,
    input  wire logic        ackPin_n,
    input  wire logic [1:0]  tmPin_n,
    input  wire logic [31:0] adPin_n,
    // Sampled
    bus_sample_if.src        smp
);
    logic [38:0] meta;
    logic [38:0] sync;
    logic        clkPrev;

    // =====================================
    // Two-flop synchroniser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= 39'h7fffffffff;
            sync <= 39'h7fffffffff;
        end else begin
            meta <= {busClkPin, resetPin_n, pfwPin_n, startPin_n, ackPin_n,
                     tmPin_n, adPin_n};
            sync <= meta;
        end
    end

    // =====================================
    // Bus clock edges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clkPrev     <= 1'b1;
            smp.sample  <= 1'b0;
            smp.drive   <= 1'b0;
        end else begin
            clkPrev     <= sync[38];
            smp.sample  <= clkPrev & ~sync[38];
            smp.drive   <= ~clkPrev & sync[38];
        end
    end

    // =====================================
    // Inverted registered inputs; bus lines at falling edge, reset and power fail every clk
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            smp.start     <= 1'b0;
            smp.ack       <= 1'b0;
            smp.tm        <= 2'h0;
            smp.ad        <= 32'h0;
            smp.busReset  <= 1'b0;
            smp.powerFail <= 1'b0;
        end else begin
            smp.busReset  <= ~sync[37];
            smp.powerFail <= ~sync[36];
            if (clkPrev & ~sync[38]) begin
                smp.start <= ~sync[35];
                smp.ack   <= ~sync[34];
                smp.tm    <= ~sync[33:32];
                smp.ad    <= ~sync[31:0];
            end
        end
    end

    // =====================================
    // Slot code, straps are static after power-up
    logic [3:0] idMeta;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idMeta   <= 4'h0;
            smp.slot <= 4'h0;
        end else begin
            idMeta   <= idPin_n;
            smp.slot <= ~idMeta;
        end
    end
endmodule

// file: hw/nubus_single_transfer_port.sv
// Bus port for single data cycle transactions, master and slave.
// Assumes the local side holds requests stable until done.
`timescale 1ns/100ps
`include "nubus_port_params.svh"
module nubus_single_transfer_port #(
    parameter bit SUPER_SLOT_EN = 1'b1
) (
    // System
    input  wire logic        clk,
    input  wire logic        rst,
    // Bus pins, active low
    input  wire logic        busClkPin,
    input  wire logic        resetPin_n,
    input  wire logic [3:0]  idPin_n,
    input  wire logic        pfwPin_n,
    input  wire logic        startIn_n,
    output logic             startOut_n,
    output logic             startOe,
    input  wire logic        ackIn_n,
    output logic             ackOut_n,
    output logic             ackOe,
    input  wire logic [1:0]  tmIn_n,
    output logic      [1:0]  tmOut_n,
    output logic             tmOe,
    input  wire logic [31:0] adIn_n,
    output logic      [31:0] adOut_n,
    output logic             adOe,
    output logic             spvOut_n,
    output logic             spvOe,
    output logic             nmrqOut_n,
    output logic             nmrqOe,
    output logic             pfwOut_n,
    output logic             pfwOe,
    // Local master request
    input  wire logic        mstReq,
    input  wire logic        mstWrite,
    input  wire logic [31:0] mstAddr,
    input  wire logic        mstWide,
    input  wire logic [31:0] mstWdata,
    output logic             mstDone,
    output logic      [1:0]  mstStatus,
    output logic      [31:0] mstRdata,
    // Local slave side
    output logic             slvReq,
    output logic             slvWrite,
    output logic      [31:0] slvAddr,
    output logic      [3:0]  slvLanes,
    output logic      [31:0] slvWdata,
    input  wire logic        slvReady,
    input  wire logic [1:0]  slvStatus,
    input  wire logic [31:0] slvRdata,
    // Service and power
    input  wire logic        serviceReq,
    input  wire logic        powerOffReq,
    output logic      [3:0]  slotId,
    output logic             powerFail
);
    bus_sample_if smp ();
    nubus_port_pkg::state_t state;
    logic [8:0] waitCnt;
    logic [7:0] rstCnt;
    logic       busInit;
    logic       slaveStart;
    logic       hit;

    bus_sampler u_sampler (
        .clk        (clk),
        .rst        (rst),
        .busClkPin  (busClkPin),
        .resetPin_n (resetPin_n),
        .idPin_n    (idPin_n),
        .pfwPin_n   (pfwPin_n),
        .startPin_n (startIn_n),
        .ackPin_n   (ackIn_n),
        .tmPin_n    (tmIn_n),
        .adPin_n    (adIn_n),
        .smp        (smp)
    );

    // =====================================
    // Lane decode from mode and low address
    function automatic logic [3:0] lanes(input logic tm0, input logic [1:0] a);
        if (!tm0)
            lanes = 4'h1 << a;
        else begin
            unique case (a)
                2'b01:   lanes = 4'h3;
                2'b11:   lanes = 4'hc;
                default: lanes = 4'hf;
            endcase
        end
    endfunction

    // Inverted pin encoding maps asserted-low L address bits to internal 1; TM0 keeps its pin level
    function automatic logic [3:0] lanesPin(input logic tm0n, input logic [1:0] an);
        lanesPin = lanes(~tm0n ? 1'b0 : 1'b1, ~an);
    endfunction

    // =====================================
    // Address decode
    assign slaveStart = smp.start & ~smp.ack;
    assign hit = (smp.ad[31:28] == `SLOT_SPACE_DIGIT && smp.ad[27:24] == smp.slot)
               || (SUPER_SLOT_EN && smp.ad[31:28] == smp.slot);

    // =====================================
    // Bus reset stretch over one bus period
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rstCnt  <= 8'h0;
            busInit <= 1'b1;
        end else if (smp.busReset) begin
            rstCnt  <= 8'h0;
            busInit <= 1'b1;
        end else if (rstCnt < 8'(`RESET_HOLD_CYC)) begin
            rstCnt  <= rstCnt + 8'h1;
        end else begin
            busInit <= 1'b0;
        end
    end

    // =====================================
    // Transaction state, changes only at bus clock rising edge or on bus reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state   <= nubus_port_pkg::IDLE;
            waitCnt <= 9'h0;
        end else if (busInit) begin
            state   <= nubus_port_pkg::IDLE;
            waitCnt <= 9'h0;
        end else if (smp.drive) begin
            unique case (state)
                nubus_port_pkg::IDLE: begin
                    waitCnt <= 9'h0;
                    if (slaveStart && hit)
                        state <= nubus_port_pkg::SWAIT;
                    else if (mstReq && !mstDone)
                        state <= nubus_port_pkg::MSTART;
                end
                nubus_port_pkg::MSTART: state <= nubus_port_pkg::MWAIT;
                nubus_port_pkg::MWAIT: begin
                    if (smp.ack && !smp.start)
                        state <= nubus_port_pkg::MREL;
                end
                nubus_port_pkg::MREL: state <= nubus_port_pkg::IDLE;
                nubus_port_pkg::SWAIT: begin
                    waitCnt <= waitCnt + 9'h1;
                    if (slvReady)
                        state <= nubus_port_pkg::SACK;
                    else if (waitCnt >= 9'(`BUS_TIMEOUT))
                        state <= nubus_port_pkg::IDLE;
                end
                nubus_port_pkg::SACK: state <= nubus_port_pkg::SREL;
                nubus_port_pkg::SREL: state <= nubus_port_pkg::IDLE;
                default: state <= nubus_port_pkg::IDLE;
            endcase
        end
    end

    // =====================================
    // Control line drivers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            startOut_n <= 1'b1;
            startOe    <= 1'b0;
            ackOut_n   <= 1'b1;
            ackOe      <= 1'b0;
            tmOut_n    <= 2'h3;
            tmOe       <= 1'b0;
        end else begin
            unique case (state)
                nubus_port_pkg::MSTART: begin
                    startOut_n <= 1'b0;
                    startOe    <= 1'b1;
                    ackOut_n   <= 1'b1;
                    ackOe      <= 1'b1;
                    tmOut_n    <= {~mstWrite, mstWide};
                    tmOe       <= 1'b1;
                end
                nubus_port_pkg::SACK: begin
                    startOut_n <= 1'b1;
                    startOe    <= 1'b0;
                    ackOut_n   <= 1'b0;
                    ackOe      <= 1'b1;
                    tmOut_n    <= slvStatus;
                    tmOe       <= 1'b1;
                end
                default: begin
                    startOut_n <= 1'b1;
                    startOe    <= 1'b0;
                    ackOut_n   <= 1'b1;
                    ackOe      <= 1'b0;
                    tmOut_n    <= 2'h3;
                    tmOe       <= 1'b0;
                end
            endcase
        end
    end

    // =====================================
    // Address and data drivers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            adOut_n <= 32'hffffffff;
            adOe    <= 1'b0;
        end else begin
            unique case (state)
                nubus_port_pkg::MSTART: begin
                    adOut_n <= ~mstAddr;
                    adOe    <= 1'b1;
                end
                nubus_port_pkg::MWAIT: begin
                    adOut_n <= mstWrite ? ~mstWdata : 32'hffffffff;
                    adOe    <= mstWrite;
                end
                nubus_port_pkg::SACK: begin
                    adOut_n <= ~slvRdata;
                    adOe    <= ~slvWrite;
                end
                default: begin
                    adOut_n <= 32'hffffffff;
                    adOe    <= 1'b0;
                end
            endcase
        end
    end

    // =====================================
    // Slave capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            slvReq   <= 1'b0;
            slvWrite <= 1'b0;
            slvAddr  <= 32'h0;
            slvLanes <= 4'h0;
            slvWdata <= 32'h0;
        end else begin
            if (state == nubus_port_pkg::IDLE && smp.drive && slaveStart && hit) begin
                slvWrite <= smp.tm[1];
                slvAddr  <= {smp.ad[31:2], 2'b00};
                slvLanes <= lanesPin(~smp.tm[0], ~smp.ad[1:0]);
            end
            if (state == nubus_port_pkg::SWAIT && smp.sample && slvWrite)
                slvWdata <= smp.ad;
            slvReq <= (state == nubus_port_pkg::SWAIT) && !busInit;
        end
    end

    // =====================================
    // Master completion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mstDone   <= 1'b0;
            mstStatus <= `ACK_COMPLETE;
            mstRdata  <= 32'h0;
        end else if (state == nubus_port_pkg::MWAIT && smp.drive && smp.ack && !smp.start) begin
            mstDone   <= 1'b1;
            mstStatus <= ~smp.tm;
            mstRdata  <= smp.ad;
        end else if (!mstReq) begin
            mstDone   <= 1'b0;
        end
    end

    // =====================================
    // Utility outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            spvOut_n  <= 1'b1;
            spvOe     <= 1'b0;
            nmrqOut_n <= 1'b1;
            nmrqOe    <= 1'b0;
            pfwOut_n  <= 1'b1;
            pfwOe     <= 1'b0;
            slotId    <= 4'h0;
            powerFail <= 1'b0;
        end else begin
            spvOut_n  <= 1'b1;
            spvOe     <= 1'b0;
            nmrqOut_n <= ~serviceReq;
            nmrqOe    <= serviceReq;
            pfwOut_n  <= 1'b0;
            pfwOe     <= powerOffReq;
            slotId    <= smp.slot;
            powerFail <= smp.powerFail;
        end
    end

    // =====================================
    // Checks
    sequence s_startCycle;
        !startOut_n && startOe;
    endsequence

    property p_startOnce;
        @(posedge clk) disable iff (rst) $fell(startOut_n) |-> ##[1:40] startOut_n;
    endproperty
    a_startOnce: assert property (p_startOnce) else $error("start too long");

    property p_ackWithStart;
        @(posedge clk) disable iff (rst) s_startCycle |-> (ackOe && ackOut_n);
    endproperty
    a_ackWithStart: assert property (p_ackWithStart) else $error("ack not driven high");

    property p_ackOnce;
        @(posedge clk) disable iff (rst) $fell(ackOut_n) |-> ##[1:40] ackOut_n;
    endproperty
    a_ackOnce: assert property (p_ackOnce) else $error("ack too long");

    property p_noSpv;
        @(posedge clk) disable iff (rst) !spvOe && spvOut_n;
    endproperty
    a_noSpv: assert property (p_noSpv) else $error("parity valid driven");

    property p_tmWithCtl;
        @(posedge clk) disable iff (rst) tmOe |-> (startOe || !ackOut_n);
    endproperty
    a_tmWithCtl: assert property (p_tmWithCtl) else $error("mode driven alone");

    property p_resetIdle;
        @(posedge clk) disable iff (rst) smp.busReset |=> ##1 (state == nubus_port_pkg::IDLE);
    endproperty
    a_resetIdle: assert property (p_resetIdle) else $error("reset ignored");

    property p_releaseAfterAck;
        @(posedge clk) disable iff (rst) $rose(ackOut_n) && state == nubus_port_pkg::SREL
            |-> !adOe;
    endproperty
    a_releaseAfterAck: assert property (p_releaseAfterAck) else $error("ad held");

    property p_driveOnRise;
        @(posedge clk) disable iff (rst) $changed(state) && !busInit |-> $past(smp.drive);
    endproperty
    a_driveOnRise: assert property (p_driveOnRise) else $error("off-edge change");
endmodule

// file: dv/bus_partner.sv
// Far-side card model: answers the port's master, addresses the port's slot.
// Assumes bus lines that nobody drives are terminated high.
`timescale 1ns/100ps
module bus_partner (
    // Bus clock
    input  wire logic        busClk,
    // Port drivers
    input  wire logic        startOut_n,
    input  wire logic        startOe,
    input  wire logic        ackOut_n,
    input  wire logic        ackOe,
    input  wire logic [1:0]  tmOut_n,
    input  wire logic        tmOe,
    input  wire logic [31:0] adOut_n,
    input  wire logic        adOe,
    // Resolved lines
    output logic             startN,
    output logic             ackN,
    output logic      [1:0]  tmN,
    output logic      [31:0] adN
);
    logic        sOe = 1'b0, sAdOe = 1'b0, mOe = 1'b0, mAdOe = 1'b0, mAck = 1'b1;
    logic        pend = 1'b0, longPulse = 1'b0, ackClash = 1'b0, prevSt = 1'b1, prevAk = 1'b1;
    logic [1:0]  sTm, mTm, cTm, stat = 2'h0;
    logic [31:0] sAd, mAd, cAddr, cData, rdata = 32'h0;
    int          lag = 1, cnt = 0;

    // ==========================================
    // Wired lines
    assign startN = startOe ? startOut_n : ~mOe;
    assign ackN   = ackOe ? ackOut_n : sOe ? 1'b0 : mOe ? mAck : 1'b1;
    assign tmN    = tmOe ? tmOut_n : sOe ? sTm : mOe ? mTm : 2'h3;
    assign adN    = adOe ? adOut_n : sAdOe ? sAd : mAdOe ? mAd : 32'hffffffff;

    // ==========================================
    // Slave side
    always @(negedge busClk) begin
        if (startOe && !startN && ackN) begin
            cAddr <= ~adN;
            cTm <= tmN;
            pend <= 1'b1;
            cnt <= 0;
        end
        if (startOe && !startN && !ackN)
            ackClash <= 1'b1;
        if (pend && cnt > 0)
            cData <= ~adN;
        if ((!(startN | ~startOe) && !prevSt) || (!(ackN | ~ackOe) && !prevAk))
            longPulse <= 1'b1;
        prevSt <= startN | ~startOe;
        prevAk <= ackN | ~ackOe;
    end

    always @(posedge busClk) begin
        if (sOe) begin
            sOe <= 1'b0;
            sAdOe <= 1'b0;
        end
        if (pend) begin
            cnt <= cnt + 1;
            if (cnt == lag) begin
                pend <= 1'b0;
                sOe <= 1'b1;
                sTm <= stat;
                sAd <= ~rdata;
                sAdOe <= cTm[1];
            end
        end
    end

    // ==========================================
    // Master side
    task automatic xfer(input logic [31:0] a, input logic [1:0] tm, input logic [31:0] d,
                        input logic att, output logic got, output logic [1:0] st,
                        output logic [31:0] rd);
        @(posedge busClk);
        mOe = 1'b1;
        mAck = ~att;
        mTm = tm;
        mAd = ~a;
        mAdOe = 1'b1;
        @(posedge busClk);
        mOe = 1'b0;
        mAd = ~d;
        mAdOe = ~tm[1];
        got = 1'b0;
        for (int n = 0; n < 40 && !got; n++) begin
            @(negedge busClk);
            if (ackN === 1'b0) begin
                got = 1'b1;
                st = tmN;
                rd = ~adN;
            end
        end
        @(posedge busClk);
        mAdOe = 1'b0;
    endtask
endmodule

// file: dv/nubus_single_transfer_port_bench.sv
// Self-checking bench for the single transfer bus port.
// Assumes the partner model holds the bus lines.
`timescale 1ns/100ps
module nubus_single_transfer_port_bench;
    // ==========================================
    // Signals
    logic        clk = 1'b0, rst = 1'b1, busClk = 1'b0, resetPin_n = 1'b1, pfwPin_n = 1'b1;
    logic        mstReq = 1'b0, mstWrite = 1'b0, mstWide = 1'b0, slvReady = 1'b0;
    logic        serviceReq = 1'b0, powerOffReq = 1'b0;
    logic [31:0] mstAddr = 32'h0, mstWdata = 32'h0, slvRdata = 32'h0, a;
    logic [1:0]  slvStatus = 2'h0, tm, tmN, tmOut_n, mstStatus;
    logic        startN, ackN, startOut_n, startOe, ackOut_n, ackOe, tmOe, adOe, spvOut_n;
    logic        spvOe, nmrqOut_n, nmrqOe, pfwOut_n, pfwOe, mstDone, slvReq, slvWrite;
    logic        powerFail, doneQ, reqQ;
    logic [31:0] adN, adOut_n, mstRdata, slvAddr, slvWdata;
    logic [3:0]  slvLanes, slotId;
    logic [68:0] e;
    logic [34:0] mstQ[$];
    logic [68:0] slvQ[$];
    int          errors = 0, samplesChecked = 0, i;
    integer      seed = 32'h06f5d76a;

    initial begin
        forever #2.5 clk = ~clk;
    end
    initial begin
        #7;
        forever begin
            busClk = 1'b1;
            #36;
            busClk = 1'b0;
            #12;
        end
    end
    always @(posedge clk) begin
        slvReady <= #1 $random(seed);
    end

    nubus_single_transfer_port u_dut (
        .clk, .rst, .busClkPin(busClk), .resetPin_n, .idPin_n(4'h6), .pfwPin_n,
        .startIn_n(startN), .startOut_n, .startOe, .ackIn_n(ackN), .ackOut_n, .ackOe,
        .tmIn_n(tmN), .tmOut_n, .tmOe, .adIn_n(adN), .adOut_n, .adOe, .spvOut_n, .spvOe,
        .nmrqOut_n, .nmrqOe, .pfwOut_n, .pfwOe, .mstReq, .mstWrite, .mstAddr, .mstWide,
        .mstWdata, .mstDone, .mstStatus, .mstRdata, .slvReq, .slvWrite, .slvAddr,
        .slvLanes, .slvWdata, .slvReady, .slvStatus, .slvRdata, .serviceReq, .powerOffReq,
        .slotId, .powerFail
    );
    bus_partner u_partner (
        .busClk, .startOut_n, .startOe, .ackOut_n, .ackOe, .tmOut_n, .tmOe, .adOut_n,
        .adOe, .startN, .ackN, .tmN, .adN
    );

    // ==========================================
    // Checking
    task automatic cmp(input string what, input logic [68:0] exp, input logic [68:0] got);
        samplesChecked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic endOfTest();
        if (errors == 0 && samplesChecked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk) begin
        doneQ <= mstDone;
        reqQ <= slvReq;
        if (mstDone === 1'b1 && doneQ !== 1'b1) begin
            e = (mstQ.size() > 0) ? mstQ.pop_front() : '1;
            cmp("master result", e, {e[34], mstStatus, e[34] ? e[31:0] : mstRdata});
        end
        if (slvReq !== 1'b1 && reqQ === 1'b1) begin
            e = (slvQ.size() > 0) ? slvQ.pop_front() : '1;
            cmp("slave request", e, {slvWrite, slvAddr, slvLanes, e[68] ? slvWdata : e[31:0]});
        end
    end

    // ==========================================
    // Drivers
    task automatic mst(input logic w, input logic [31:0] ad, input logic wide,
                       input logic [1:0] st);
        logic [31:0] d;
        int          n;
        d = $random(seed);
        u_partner.stat = st;
        u_partner.rdata = $random(seed);
        u_partner.lag = 1 + $unsigned($random(seed)) % 4;
        mstQ.push_back({w, st, u_partner.rdata});
        @(posedge clk);
        #1;
        mstReq = 1'b1;
        mstWrite = w;
        mstAddr = ad;
        mstWide = wide;
        mstWdata = d;
        for (n = 0; n < 4000 && mstDone !== 1'b1; n++)
            @(posedge clk);
        #1;
        mstReq = 1'b0;
        cmp("master done", 1'b1, mstDone);
        cmp("start address", ad, u_partner.cAddr);
        cmp("start mode", {~w, wide}, u_partner.cTm);
        if (w)
            cmp("write data", d, u_partner.cData);
        for (n = 0; n < 100 && mstDone === 1'b1; n++)
            @(posedge clk);
    endtask

    task automatic slv(input logic [31:0] ad, input logic [1:0] tmc, input logic att,
                       input logic hit);
        logic [31:0] d, rd;
        logic [3:0]  ln;
        logic [1:0]  st;
        logic        got;
        d = $random(seed);
        ln = !tmc[0] ? 4'h1 << ad[1:0] : ad[1:0] == 2'h0 ? 4'hf : ad[1] ? 4'hc : 4'h3;
        @(posedge clk);
        #1;
        slvStatus = $random(seed);
        slvRdata = $random(seed);
        if (hit)
            slvQ.push_back({~tmc[1], ad[31:2], 2'h0, ln, d});
        u_partner.xfer(ad, tmc, d, att, got, st, rd);
        cmp("slave answered", hit, got);
        if (got) begin
            cmp("ack status", slvStatus, st);
            if (tmc[1])
                cmp("read data", slvRdata, rd);
        end
    endtask

    // ==========================================
    // Sequence
    initial begin
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (40) @(posedge clk);
        cmp("idle outputs", {4'h9, 6'h0}, {slotId, startOe, ackOe, tmOe, adOe, spvOe, nmrqOe});
        for (i = 0; i < 8; i++) begin
            a = {4'h3, 28'($random(seed))};
            tm[0] = $random(seed);
            if (tm[0] && a[1:0] == 2'h2)
                a[1:0] = 2'h0;
            mst(i[0], a, tm[0], i[2:1]);
        end
        for (i = 0; i < 8; i++) begin
            a = i[0] ? {8'hf9, 24'($random(seed))} : {4'h9, 28'($random(seed))};
            tm = i[2:1];
            if (tm[0] && a[1:0] == 2'h2)
                a[1:0] = 2'h0;
            slv(a, tm, 1'b0, 1'b1);
        end
        slv(32'hfa000000, 2'h3, 1'b0, 1'b0);
        slv(32'hf9000000, 2'h3, 1'b1, 1'b0);
        u_partner.lag = 30;
        @(posedge clk);
        #1;
        mstReq = 1'b1;
        mstWrite = 1'b1;
        mstAddr = 32'h30000000;
        repeat (150) @(posedge clk);
        #1;
        resetPin_n = 1'b0;
        repeat (20) @(posedge clk);
        cmp("bus release on reset", 4'h0, {startOe, ackOe, tmOe, adOe});
        #1;
        resetPin_n = 1'b1;
        mstReq = 1'b0;
        repeat (800) @(posedge clk);
        #1;
        serviceReq = 1'b1;
        powerOffReq = 1'b1;
        pfwPin_n = 1'b0;
        repeat (10) @(posedge clk);
        cmp("service and power", 5'h15, {nmrqOe, nmrqOut_n, pfwOe, pfwOut_n, powerFail});
        cmp("bus pulse lengths", 2'h0, {u_partner.longPulse, u_partner.ackClash});
        cmp("queues drained", 69'h0, mstQ.size() + slvQ.size());
        endOfTest();
    end

    initial begin
        #200000;
        errors++;
        endOfTest();
    end
endmodule
